// ### shared/upgrade_params.svh
/*
 * Constants of the remote-upgrade user control: source codes, field positions,
 * watchdog and boot address settings, timing counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef UPGRADE_PARAMS_SVH
`define UPGRADE_PARAMS_SVH
`define SRC_MSB 30
`define SRC_LSB 26
`define SRC_POWER_UP 5'h00
`define SRC_CORE_REQ 5'h01
`define SRC_WATCHDOG 5'h02
`define SRC_STATUS_ERR 5'h04
`define SRC_CRC_ERR 5'h08
`define SRC_EXT_REQ 5'h10
`define WD_TIMEOUT_CYCLES 40894472
`define WD_HIGH_BITS 12
`define WD_LOW_FILL 17'h00008
`define WD_TIMEOUT_HIGH 12'h138
`define BOOT_HIGH_BITS 22
`define BOOT_ADDR_DEFAULT 22'h01C000
`define KICK_PERIOD 33554432
`define KICK_CNT_W 25
`define CLK_PERIOD_NS 40
`define RECONFIG_MIN_NS 250
`define RECONFIG_CYCLES ((`RECONFIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LEDS_FACTORY 4'hF
`define LEDS_WATCHDOG 4'hA
`define LEDS_STATUS_ERR 4'h9
`define LEDS_CRC_ERR 4'h6
`define LEDS_EXT_REQ 4'hE
`define LEDS_UNKNOWN 4'h0
`endif

// ### shared/upgrade_pkg.sv
/*
 * Types of the remote-upgrade user control.
 * Assumes the constants header is on the include path.
 */
`include "upgrade_params.svh"
package upgrade_pkg;
  typedef struct packed {
    logic reconfig;
    logic wd_reset;
    logic wd_enable;
    logic [`WD_HIGH_BITS-1:0] wd_timeout;
    logic [`BOOT_HIGH_BITS-1:0] boot_addr;
  } upgrade_ctrl_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_READY, ST_LAUNCH, ST_DONE} ctrl_state_t;
endpackage

// ### verilog/kick_counter.sv
/*
 * Periodic watchdog kicker: one pulse each kick period while enabled.
 * Assumes a single clock shared with the instantiating module.
 */
`timescale 1ns/1ns
`include "upgrade_params.svh"
module kick_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  output logic kick_o
);
  logic [`KICK_CNT_W-1:0] count_r;
  localparam logic [`KICK_CNT_W-1:0] LAST = `KICK_CNT_W'(`KICK_PERIOD - 1);
  // Disabling clears the count so a re-enable starts a full period later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      kick_o <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i) begin
        count_r <= '0; // R17
        kick_o <= 1'b0; // R17
      end else begin
        count_r <= (count_r == LAST) ? '0 : count_r + 1'b1; // R10
        kick_o <= (count_r == LAST); // R10
      end
    end
  end
  a_kick_when_off: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    !enable_i && ce_i |=> !kick_o) else $error("kick while disabled");
endmodule // kick_counter

// ### verilog/upgrade_control.sv
/*
 * Factory-image user control for the on-chip remote upgrade circuitry: reads the
 * reconfiguration source, shows it on four indicators, programs watchdog and boot
 * address, launches reconfiguration on a button, and kicks the watchdog.
 * Assumes the upgrade circuitry answers reads on the same 25 MHz clock, and that
 * buttons arrive asynchronously from the board.
 */
`timescale 1ns/1ns
`include "upgrade_params.svh"
// Functional notes
// R1 - A power-up load of the factory image reads source code zero in status bits 30 to 26.
// R2 - A core-requested reload reads source code with only the lowest bit set.
// R3 - A watchdog expiry in an application reloads the factory image with the watchdog code.
// R4 - A low configuration status line reloads the factory image with the status-error code.
// R5 - A CRC error while loading an application falls back with the CRC-error code.
// R6 - An external configuration request reloads the factory image with its own code.
// R7 - On error the circuitry updates the status before triggering the factory reload.
// R8 - Factory user logic learns the cause from the five-bit field at bits 30 down to 26.
// R9 - The factory image programs a watchdog time-out of 40894472 cycles of 10 MHz.
// R10 - The kicker pulses the watchdog reset once every 33554432 board clock cycles; the kicker here counts 33554432 cycles of the 25 MHz clock instead.
// R11 - Entering the factory image at power-up or by core request lights all four indicators.
// R12 - The launch input starts a reconfiguration request toward the upgrade circuitry.
// R13 - The reconfigure input is held high for at least 250 ns.
// R14 - Only the upper 12 of the 29 watchdog bits are written; the low 17 are filled in.
// R15 - The upper 22 of the 24 boot address bits are written; two zero bits are appended.
// R16 - The upgrade interface runs on the board clock divided by two, 25 MHz.
// R17 - The kicker stops while disabled and restarts from zero when re-enabled.
module upgrade_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic launch_btn_i,
  input wire logic kick_enable_i,
  input wire logic [31:0] status_word_i,
  input wire logic status_valid_i,
  output upgrade_pkg::upgrade_ctrl_t ctrl_o,
  output logic status_read_o,
  output logic [4:0] source_o,
  output logic [3:0] leds_o,
  output logic busy_o
);
  import upgrade_pkg::*;

  localparam int RC_CYC = (`RECONFIG_CYCLES < 1) ? 1 : `RECONFIG_CYCLES;
  localparam logic [3:0] RC_LAST = 4'(RC_CYC - 1);

  logic btn_meta_r, btn_sync_r, btn_prev_r, kick_meta_r, kick_sync_r;
  logic launch_edge;
  ctrl_state_t state_r;
  logic [3:0] hold_r;
  logic kick_pulse;
  logic reconfig_r, wd_reset_r, wd_enable_r;
  logic [`WD_HIGH_BITS-1:0] wd_timeout_r;
  logic [`BOOT_HIGH_BITS-1:0] boot_addr_r;

  // Each field has one writing process; the struct is only wiring, in its packed order.
  assign ctrl_o = {reconfig_r, wd_reset_r, wd_enable_r, wd_timeout_r, boot_addr_r};

  // Button and enable come from board pins: two flops before use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_meta_r <= 1'b0;
      btn_sync_r <= 1'b0;
      btn_prev_r <= 1'b0;
      kick_meta_r <= 1'b0;
      kick_sync_r <= 1'b0;
    end else if (ce_i) begin
      btn_meta_r <= launch_btn_i;
      btn_sync_r <= btn_meta_r;
      btn_prev_r <= btn_sync_r;
      kick_meta_r <= kick_enable_i;
      kick_sync_r <= kick_meta_r;
    end
  end
  assign launch_edge = btn_sync_r && !btn_prev_r;

  // Sequence: read status, decode, wait for button, hold reconfigure.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      hold_r <= 4'h0;
      status_read_o <= 1'b0;
      reconfig_r <= 1'b0;
      busy_o <= 1'b1;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          status_read_o <= 1'b1;
          state_r <= ST_DECODE;
        end
        ST_DECODE: begin
          if (status_valid_i) begin
            status_read_o <= 1'b0;
            busy_o <= 1'b0;
            state_r <= ST_READY;
          end
        end
        ST_READY: begin
          if (launch_edge) begin // R12
            reconfig_r <= 1'b1;
            hold_r <= 4'h0;
            busy_o <= 1'b1;
            state_r <= ST_LAUNCH;
          end
        end
        ST_LAUNCH: begin
          // Held a full minimum time; the circuitry then tears the image down.
          if (hold_r == RC_LAST) begin // R13
            reconfig_r <= 1'b0;
            state_r <= ST_DONE;
          end else begin
            hold_r <= hold_r + 4'h1;
          end
        end
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Source decode to indicators. Unknown or mixed codes leave the indicators dark.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_o <= `SRC_POWER_UP;
      leds_o <= 4'h0;
    end else if (ce_i && state_r == ST_DECODE && status_valid_i) begin
      source_o <= status_word_i[`SRC_MSB:`SRC_LSB]; // R8
      case (status_word_i[`SRC_MSB:`SRC_LSB])
        `SRC_POWER_UP: leds_o <= `LEDS_FACTORY; // R1 R11
        `SRC_CORE_REQ: leds_o <= `LEDS_FACTORY; // R2 R11
        `SRC_WATCHDOG: leds_o <= `LEDS_WATCHDOG; // R3
        `SRC_STATUS_ERR: leds_o <= `LEDS_STATUS_ERR; // R4
        `SRC_CRC_ERR: leds_o <= `LEDS_CRC_ERR; // R5
        `SRC_EXT_REQ: leds_o <= `LEDS_EXT_REQ; // R6 R7
        default: leds_o <= `LEDS_UNKNOWN;
      endcase
    end
  end

  // Settings the circuitry takes on reconfiguration; its low bits are fixed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_enable_r <= 1'b0;
      wd_timeout_r <= `WD_TIMEOUT_HIGH; // R9 R14
      boot_addr_r <= `BOOT_ADDR_DEFAULT; // R15
    end else if (ce_i) begin
      wd_enable_r <= 1'b1;
      wd_timeout_r <= `WD_TIMEOUT_HIGH; // R9 R14
      boot_addr_r <= `BOOT_ADDR_DEFAULT; // R15
    end
  end

  // The kicker counts cycles of this clock, so its period in time is twice the board figure;
  // it still ends well inside the watchdog time-out.
  kick_counter u_kick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enable_i(kick_sync_r),
    .kick_o(kick_pulse)
  );

  // Registered again so the output comes from a flop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_r <= 1'b0;
    end else if (ce_i) begin
      wd_reset_r <= kick_pulse; // R10
    end
  end

  // One check per source code; the expected lamp patterns are written out on purpose.
  a_power_up_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h00
    |=> leds_o == 4'hF) else $error("power-up leds wrong");
  a_core_req_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h01
    |=> leds_o == 4'hF) else $error("core request leds wrong");
  a_watchdog_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h02
    |=> leds_o == 4'hA) else $error("watchdog leds wrong");
  a_status_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h04
    |=> leds_o == 4'h9) else $error("status error leds wrong");
  a_crc_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h08
    |=> leds_o == 4'h6) else $error("crc leds wrong");
  a_ext_req_leds: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    ce_i && state_r == ST_DECODE && status_valid_i && status_word_i[30:26] == 5'h10
    |=> leds_o == 4'hE && source_o == 5'h10) else $error("ext request wrong");

  a_reconfig_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // R13
    $rose(ctrl_o.reconfig) |-> ctrl_o.reconfig [*7]) else $error("reconfig too short");
  a_launch_start: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    ce_i && state_r == ST_READY && launch_edge |=> ctrl_o.reconfig)
    else $error("launch ignored");
  // The drop is pinned as well, so that a hold which never ends is caught too.
  a_reconfig_drop: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // R13
    $rose(ctrl_o.reconfig) |-> ##7 !ctrl_o.reconfig) else $error("reconfig held too long");
  a_no_relaunch: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    ce_i && state_r == ST_DONE |=> !ctrl_o.reconfig) else $error("second launch");
  a_launch_busy: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    ce_i && state_r == ST_READY && launch_edge |=> busy_o) else $error("busy not raised");

  a_read_request: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    ce_i && state_r == ST_IDLE |=> status_read_o) else $error("status read not requested");
  a_read_done: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    ce_i && state_r == ST_DECODE && status_valid_i |=> !status_read_o && !busy_o)
    else $error("status read not closed");

  // Settings handed to the circuitry must form the full watchdog word and the boot page.
  a_wd_word: assert property (@(posedge clk_i) disable iff (rst_i) // R9 R14
    {ctrl_o.wd_timeout, 17'h00008} == 29'h2700008) else $error("watchdog word wrong");
  a_boot_page: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    ctrl_o.boot_addr == 22'h01C000) else $error("boot address wrong");

  a_kick_single: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    ctrl_o.wd_reset |=> !ctrl_o.wd_reset) else $error("kick pulse too long");
  // The output flop adds one stage, so a disable shows on the pin two edges later.
  a_kick_stops: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // R17
    !kick_sync_r |-> ##2 !ctrl_o.wd_reset) else $error("kick after disable");

  // A low clock enable must freeze the sequence and the indicators.
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(state_r) && $stable(leds_o)) else $error("state moved with enable low");
endmodule // upgrade_control

// ### tb/upgrade_model.sv
/*
 * Behavioural model of the on-chip upgrade circuitry's status read port.
 * Assumes the control block raises its read request on the shared 25 MHz clock.
 */
`timescale 1ns/1ns
module upgrade_model (
  input wire logic clk_i,
  input wire logic read_i,
  input wire logic [4:0] code_i,
  output logic [31:0] word_o,
  output logic valid_o
);
  logic [1:0] wait_r;
  // The answer is held back three cycles so that the reader cannot rely on a prompt reply.
  always_ff @(posedge clk_i) begin
    wait_r <= read_i ? wait_r + 2'h1 : 2'h0;
  end
  assign valid_o = read_i & (wait_r == 2'h3);
  // Outside a valid answer the word shows the inverse, so a stale sample reads wrong.
  assign word_o = valid_o ? {1'b0, code_i, 26'h2AAAAAA}
                          : {1'b1, ~code_i, 26'h1555555};
endmodule // upgrade_model

// ### tb/testbench.sv
/*
 * Self-checking bench of the upgrade user control with the circuitry model.
 * Assumes the design's package and constants header are compiled first.
 */
`timescale 1ns/1ns
module testbench;
  import upgrade_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic launch_btn_i = 1'b0;
  logic kick_enable_i = 1'b0;
  logic ce_i = 1'b1;
  logic [4:0] code = 5'h00;
  logic [31:0] status_word_i;
  logic status_valid_i;
  upgrade_ctrl_t ctrl_o;
  logic status_read_o;
  logic [4:0] source_o;
  logic [3:0] leds_o;
  logic busy_o;
  int failures = 0;
  int checked = 0;
  always #20 clk_i = ~clk_i;
  upgrade_control upgrade_control_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .launch_btn_i(launch_btn_i), .kick_enable_i(kick_enable_i),
    .status_word_i(status_word_i), .status_valid_i(status_valid_i), .ctrl_o(ctrl_o),
    .status_read_o(status_read_o), .source_o(source_o), .leds_o(leds_o), .busy_o(busy_o));
  upgrade_model upgrade_model_inst (.clk_i(clk_i), .read_i(status_read_o), .code_i(code),
    .word_o(status_word_i), .valid_o(status_valid_i));
  task automatic end_of_test;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [36:0] got, input logic [36:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Resets with the given cause waiting in the model, then waits for the decode.
  task automatic boot(input logic [4:0] c);
    int n;
    @(negedge clk_i);
    rst_i = 1'b1;
    code = c;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    n = 0;
    while (busy_o !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    cmp(37'(n < 40), 37'h1);
  endtask
  task automatic source_table;
    logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};
    logic [3:0] leds [7] = '{4'hF, 4'hF, 4'hA, 4'h9, 4'h6, 4'hE, 4'h0};
    for (int i = 0; i < 7; i++) begin
      boot(codes[i]);
      cmp(37'(source_o), 37'(codes[i]));
      cmp(37'(leds_o), 37'(leds[i]));
      cmp(37'(status_read_o), 37'h0);
    end
  endtask
  task automatic launch_once;
    int n;
    int hold;
    boot(5'h00);
    cmp(37'(ctrl_o.wd_timeout), 37'h138);
    cmp(37'({ctrl_o.wd_timeout, 17'h00008}), 37'(40894472));
    cmp(37'(ctrl_o.boot_addr), 37'h01C000);
    cmp(37'(ctrl_o.wd_enable), 37'h1);
    launch_btn_i = 1'b1;
    n = 0;
    while (ctrl_o.reconfig !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    cmp(37'(n), 37'h3);
    hold = 0;
    while (ctrl_o.reconfig === 1'b1 && hold < 20) begin
      @(negedge clk_i);
      hold++;
    end
    cmp(37'(hold * 40 >= 250), 37'h1);
    cmp(37'(hold), 37'h7);
    cmp(37'(busy_o), 37'h1);
    launch_btn_i = 1'b0;
    repeat (4) @(negedge clk_i);
    launch_btn_i = 1'b1;
    // A second press after the launch must stay invisible.
    repeat (12) begin
      @(negedge clk_i);
      cmp(37'(ctrl_o.reconfig), 37'h0);
    end
    launch_btn_i = 1'b0;
  endtask
  // The full period is far too long to run; this only shows no stray pulse appears.
  task automatic kick_quiet;
    boot(5'h00);
    kick_enable_i = 1'b1;
    repeat (300) begin
      @(negedge clk_i);
      cmp(37'(ctrl_o.wd_reset), 37'h0);
    end
    kick_enable_i = 1'b0;
    repeat (100) begin
      @(negedge clk_i);
      cmp(37'(ctrl_o.wd_reset), 37'h0);
    end
  endtask
  // The enable stays low across the reset release: nothing may move until it returns.
  task automatic ce_freeze;
    int n;
    @(negedge clk_i);
    rst_i = 1'b1;
    code = 5'h08;
    ce_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    cmp(37'(status_read_o), 37'h0);
    cmp(37'(busy_o), 37'h1);
    cmp(37'(leds_o), 37'h0);
    ce_i = 1'b1;
    n = 0;
    while (busy_o !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    cmp(37'(n), 37'h5);
    cmp(37'(leds_o), 37'h6);
    cmp(37'(source_o), 37'h08);
  endtask
  initial begin
    source_table();
    launch_once();
    kick_quiet();
    ce_freeze();
    end_of_test();
  end
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule // testbench
